// file: include/kgc_pkg.sv
// keyclick and gain step control: constants shared by the rtl files
// assumes one 125 MHz system clock and a simple parallel register port
package kgc_pkg;

   // register port
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 16;
   localparam logic [7:0]  CTRL_OFFSET  = 8'h04;

   // field positions
   localparam int EN_BIT        = 15;
   localparam int AMP_HI        = 14;
   localparam int AMP_LO        = 12;
   localparam int IN_RATE_BIT   = 11;
   localparam int FRQ_HI        = 10;
   localparam int FRQ_LO        = 8;
   localparam int LEN_HI        = 7;
   localparam int LEN_LO        = 4;
   localparam int LDONE_BIT     = 3;
   localparam int RDONE_BIT     = 2;
   localparam int DAC_RATE_BIT  = 1;
   localparam int IN_DONE_BIT   = 0;

   // reset values
   localparam logic [2:0]  AMP_RST   = 3'h4;
   localparam logic [2:0]  FRQ_RST   = 3'h4;
   localparam logic [3:0]  LEN_RST   = 4'h1;
   localparam logic [6:0]  GAIN_RST  = 7'h7f;

   // gain code width, half-dB per code
   localparam int GAIN_W = 7;

   // click timing: lowest tone in millihertz, clock in hertz
   localparam longint unsigned CLK_HZ        = 64'd125000000;
   localparam longint unsigned CLICK_BASE_MHZ = 64'd62500;
   localparam longint unsigned CLICK_BASE_CYC =
      (CLK_HZ * 64'd1000) / CLICK_BASE_MHZ;
   localparam int PERIOD_W = 21;
   localparam int COUNT_W  = 6;

   // burst sequencer states
   typedef enum logic [1:0] {
      KGC_IDLE = 2'b00,
      KGC_RUN  = 2'b01,
      KGC_HOLD = 2'b10
   } kgc_state_t;

endpackage

// file: rtl/kgc_click_gen.sv
// keyclick tone burst: square wave for a latched number of periods
// assumes enable is a level from the control register, same clock
`timescale 1ns/1ps
module kgc_click_gen #(
   parameter int unsigned BASE_CYC = 32'(kgc_pkg::CLICK_BASE_CYC)
) (
   input  wire logic        clk_sys,     // system clock
   input  wire logic        rst_n,       // async reset, active low
   input  wire logic        enable,      // click enable level
   input  wire logic [2:0]  amp,         // amplitude code
   input  wire logic [2:0]  freq,        // frequency code
   input  wire logic [3:0]  len,         // length code
   output logic             tone,        // square wave
   output logic [2:0]       level,       // amplitude while playing
   output logic             finished     // one-cycle end pulse
);
   import kgc_pkg::*;

   kgc_state_t            state_q, state_d;     // sequencer
   logic [PERIOD_W-1:0]   per_q, per_d;         // latched period
   logic [PERIOD_W-1:0]   cnt_q, cnt_d;         // cycle in period
   logic [COUNT_W-1:0]    left_q, left_d;       // periods to go
   logic [2:0]            amp_q, amp_d;         // latched amplitude
   logic                  tone_q, tone_d;
   logic [2:0]            level_q, level_d;
   logic                  fin_q, fin_d;

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_d = state_q;
      per_d   = per_q;
      cnt_d   = cnt_q;
      left_d  = left_q;
      amp_d   = amp_q;
      tone_d  = 1'b0;
      level_d = 3'h0;
      fin_d   = 1'b0;
      case (state_q)
         KGC_IDLE: begin
            // settings are caught once, changes mid-burst wait
            if (enable) begin
               per_d   = PERIOD_W'(BASE_CYC >> freq);
               left_d  = {1'b0, len, 1'b0} + COUNT_W'(2);
               amp_d   = amp;
               cnt_d   = '0;
               state_d = KGC_RUN;
            end
         end
         KGC_RUN: begin
            if (!enable) begin
               state_d = KGC_IDLE;
            end else begin
               tone_d  = (cnt_q < (per_q >> 1));
               level_d = amp_q;
               cnt_d   = cnt_q + 1'b1;
               if (cnt_q == per_q - 1'b1) begin
                  cnt_d  = '0;
                  left_d = left_q - 1'b1;
                  if (left_q == COUNT_W'(1)) begin
                     fin_d   = 1'b1;
                     state_d = KGC_HOLD;
                  end
               end
            end
         end
         KGC_HOLD: begin
            // wait for the cleared bit so the burst cannot retrigger
            if (!enable) begin
               state_d = KGC_IDLE;
            end
         end
         default: state_d = KGC_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= KGC_IDLE;
         per_q   <= '0;
         cnt_q   <= '0;
         left_q  <= '0;
         amp_q   <= AMP_RST;
         tone_q  <= 1'b0;
         level_q <= 3'h0;
         fin_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         per_q   <= per_d;
         cnt_q   <= cnt_d;
         left_q  <= left_d;
         amp_q   <= amp_d;
         tone_q  <= tone_d;
         level_q <= level_d;
         fin_q   <= fin_d;
      end
   end

   assign tone     = tone_q;
   assign level    = level_q;
   assign finished = fin_q;

endmodule // kgc_click_gen

// file: rtl/kgc_ctrl.sv
// keyclick and gain step control register with its gain steppers
// assumes word clock and adc strobe arrive from pins, async to clk_sys;
// agc status and gain targets come from logic on clk_sys
`timescale 1ns/1ps
module kgc_ctrl #(
   parameter int unsigned CLICK_BASE_CYC = 32'(kgc_pkg::CLICK_BASE_CYC)
) (
   input  wire logic                      clk_sys,        // system clock
   input  wire logic                      rst_n,          // async reset
   input  wire logic [kgc_pkg::ADDR_W-1:0] reg_addr,      // reg address
   input  wire logic                      reg_wr,         // write strobe
   input  wire logic                      reg_rd,         // read strobe
   input  wire logic [kgc_pkg::DATA_W-1:0] reg_wdata,     // write data
   output logic      [kgc_pkg::DATA_W-1:0] reg_rdata,     // read data
   input  wire logic                      wclk_pin,       // word clock
   input  wire logic                      adc_word_strobe, // adc strobe
   input  wire logic                      in_use_adc_strobe, // in tick
   input  wire logic                      agc_enable,     // agc active
   input  wire logic                      agc_noise_below, // noise flag
   input  wire logic                      agc_saturated,  // sat flag
   input  wire logic [kgc_pkg::GAIN_W-1:0] left_target,   // left dac
   input  wire logic [kgc_pkg::GAIN_W-1:0] right_target,  // right dac
   input  wire logic [kgc_pkg::GAIN_W-1:0] in_target,     // input pga
   output logic      [kgc_pkg::GAIN_W-1:0] left_gain,     // applied
   output logic      [kgc_pkg::GAIN_W-1:0] right_gain,    // applied
   output logic      [kgc_pkg::GAIN_W-1:0] in_gain,       // applied
   output logic                           click_tone,     // tone wave
   output logic      [2:0]                click_level     // amplitude
);
   import kgc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and rising edge ticks
   logic [2:0] wclk_sync_q, wclk_sync_d;   // two sync stages + history
   logic [2:0] adc_sync_q, adc_sync_d;
   logic       wclk_tick;                  // word clock edge pulse
   logic       adc_tick;                   // adc strobe edge pulse
   logic       in_tick;                    // input pga step source

   always_comb begin
      wclk_sync_d = {wclk_sync_q[1:0], wclk_pin};
      adc_sync_d  = {adc_sync_q[1:0], adc_word_strobe};
      // edge looks only at stages two and three
      wclk_tick = wclk_sync_q[1] & ~wclk_sync_q[2];
      adc_tick  = adc_sync_q[1] & ~adc_sync_q[2];
      in_tick   = in_use_adc_strobe ? adc_tick : wclk_tick;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wclk_sync_q <= 3'h0;
         adc_sync_q  <= 3'h0;
      end else begin
         wclk_sync_q <= wclk_sync_d;
         adc_sync_q  <= adc_sync_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control fields
   logic       en_q, en_d;                 // click enable
   logic [2:0] amp_q, amp_d;               // click amplitude
   logic       in_rate_q, in_rate_d;       // input gain step rate
   logic [2:0] frq_q, frq_d;               // click frequency
   logic [3:0] len_q, len_d;               // click length
   logic       dac_rate_q, dac_rate_d;     // dac gain step rate
   logic       burst_end;                  // click generator finished
   logic       hit;                        // access to this register
   logic       l_done, r_done, i_done;     // stepper flags
   logic [DATA_W-1:0] rd_word;             // assembled read value
   logic [DATA_W-1:0] rdata_q, rdata_d;    // registered read data

   always_comb begin
      hit        = (reg_addr == CTRL_OFFSET);
      en_d       = en_q;
      amp_d      = amp_q;
      in_rate_d  = in_rate_q;
      frq_d      = frq_q;
      len_d      = len_q;
      dac_rate_d = dac_rate_q;
      // hardware clear first, so a same-cycle write of one wins
      if (burst_end) begin
         en_d = 1'b0;
      end
      if (reg_wr && hit) begin
         en_d       = reg_wdata[EN_BIT];
         amp_d      = reg_wdata[AMP_HI:AMP_LO];
         frq_d      = reg_wdata[FRQ_HI:FRQ_LO];
         len_d      = reg_wdata[LEN_HI:LEN_LO];
         dac_rate_d = reg_wdata[DAC_RATE_BIT];
         // bit 11 is a flag under agc, so the write is dropped
         if (!agc_enable) begin
            in_rate_d = reg_wdata[IN_RATE_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         en_q       <= 1'b0;
         amp_q      <= AMP_RST;
         in_rate_q  <= 1'b0;
         frq_q      <= FRQ_RST;
         len_q      <= LEN_RST;
         dac_rate_q <= 1'b0;
      end else begin
         en_q       <= en_d;
         amp_q      <= amp_d;
         in_rate_q  <= in_rate_d;
         frq_q      <= frq_d;
         len_q      <= len_d;
         dac_rate_q <= dac_rate_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path: flags are live, bits 3 2 0 never take write data
   always_comb begin
      rd_word                = '0;
      rd_word[EN_BIT]        = en_q;
      rd_word[AMP_HI:AMP_LO] = amp_q;
      rd_word[IN_RATE_BIT]   = agc_enable ? agc_noise_below
                                          : in_rate_q;
      rd_word[FRQ_HI:FRQ_LO] = frq_q;
      rd_word[LEN_HI:LEN_LO] = len_q;
      rd_word[LDONE_BIT]     = l_done;
      rd_word[RDONE_BIT]     = r_done;
      rd_word[DAC_RATE_BIT]  = dac_rate_q;
      rd_word[IN_DONE_BIT]   = agc_enable ? agc_saturated
                                          : i_done;
      rdata_d = rdata_q;
      if (reg_rd) begin
         // unmapped addresses read as zero
         rdata_d = hit ? rd_word : '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////
   // gain steppers, dac pair on word clock, input on chosen strobe
   kgc_gain_stepper #(
      .W         (GAIN_W),
      .RESET_VAL (GAIN_RST)
   ) u_left (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .tick      (wclk_tick),
      .half_rate (dac_rate_q),
      .target    (left_target),
      .applied   (left_gain),
      .done      (l_done)
   );

   kgc_gain_stepper #(
      .W         (GAIN_W),
      .RESET_VAL (GAIN_RST)
   ) u_right (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .tick      (wclk_tick),
      .half_rate (dac_rate_q),
      .target    (right_target),
      .applied   (right_gain),
      .done      (r_done)
   );

   kgc_gain_stepper #(
      .W         (GAIN_W),
      .RESET_VAL (GAIN_RST)
   ) u_input (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .tick      (in_tick),
      .half_rate (in_rate_q),
      .target    (in_target),
      .applied   (in_gain),
      .done      (i_done)
   );

   ////////////////////////////////////////////////////////////////////
   // keyclick burst
   kgc_click_gen #(
      .BASE_CYC (CLICK_BASE_CYC)
   ) u_click (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .enable   (en_q),
      .amp      (amp_q),
      .freq     (frq_q),
      .len      (len_q),
      .tone     (click_tone),
      .level    (click_level),
      .finished (burst_end)
   );

endmodule // kgc_ctrl

// file: rtl/kgc_gain_stepper.sv
// one soft-stepping gain channel: moves the applied code one step a tick, or every second tick at half rate
// assumes tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/1ps
module kgc_gain_stepper #(
   parameter int              W         = kgc_pkg::GAIN_W,
   parameter logic [W-1:0]    RESET_VAL = kgc_pkg::GAIN_RST
) (
   input  wire logic          clk_sys,    // system clock
   input  wire logic          rst_n,      // async reset, active low
   input  wire logic          tick,       // word strobe pulse
   input  wire logic          half_rate,  // step on every second tick
   input  wire logic [W-1:0]  target,     // programmed gain code
   output logic      [W-1:0]  applied,    // applied gain code
   output logic               done        // applied equals target
);
   import kgc_pkg::*;

   logic [W-1:0] applied_q, applied_d;   // current code
   logic         phase_q, phase_d;       // tick divider for half rate
   logic         done_q, done_d;         // reached flag
   logic         step;                   // a step happens this cycle

   ////////////////////////////////////////////////////////////////////
   // next state: one code per permitted tick, toward the target
   always_comb begin
      phase_d   = phase_q;
      applied_d = applied_q;
      step      = 1'b0;
      if (tick) begin
         phase_d = ~phase_q;
         step    = ~half_rate | phase_q;
      end
      if (step && applied_q < target) begin
         applied_d = applied_q + 1'b1;
      end else if (step && applied_q > target) begin
         applied_d = applied_q - 1'b1;
      end
      // flag follows the compare, so a new target drops it at once
      done_d = (applied_d == target);
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         applied_q <= RESET_VAL;
         phase_q   <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         applied_q <= applied_d;
         phase_q   <= phase_d;
         done_q    <= done_d;
      end
   end

   assign applied = applied_q;
   assign done    = done_q;

endmodule // kgc_gain_stepper

// file: tb/keyclick_and_gain_step_control_bench.sv
// testbench: click bursts, gain stepping and flags against a model
// assumes a shortened click base count so bursts stay short
`timescale 1ns/1ps
module keyclick_and_gain_step_control_bench;
   import kgc_pkg::*;
   localparam int BASE = 512; // click base period in cycles
   logic        clk_sys = 1'b0, rst_n = 1'b0; // clock, reset
   logic [7:0]  reg_addr; // from host
   logic        reg_wr, reg_rd; // strobes
   logic [15:0] reg_wdata, reg_rdata, got, w; // data
   logic        wclk_pin = 0, adc_word_strobe = 0; // tick pins
   logic        in_use_adc_strobe = 0, agc_enable = 0; // modes
   logic        agc_noise_below = 0, agc_saturated = 0; // agc flags
   logic [6:0]  left_target = 7'h7f, right_target = 7'h7f; // targets
   logic [6:0]  in_target = 7'h7f, left_gain, right_gain, in_gain; // gains
   logic        click_tone, last_tone; // tone
   logic [2:0]  click_level, lvl_seen; // level
   logic [3:0]  len; // length code
   logic [15:0] shadow = 16'h4410; // model of the writable bits
   int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'h336a_9d92;
   int lg = 127, rg = 127, ig = 127, rises, last_rise, gap, v, per, k;
   kgc_host host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   kgc_ctrl #(.CLICK_BASE_CYC(BASE)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wclk_pin(wclk_pin),
      .adc_word_strobe(adc_word_strobe),
      .in_use_adc_strobe(in_use_adc_strobe), .agc_enable(agc_enable),
      .agc_noise_below(agc_noise_below), .agc_saturated(agc_saturated),
      .left_target(left_target), .right_target(right_target),
      .in_target(in_target), .left_gain(left_gain),
      .right_gain(right_gain), .in_gain(in_gain),
      .click_tone(click_tone), .click_level(click_level));
   initial forever #4 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   // tone edge monitor and run limit
   always @(negedge clk_sys) begin
      cycles++;
      if (click_tone === 1'b1 && last_tone !== 1'b1) begin
         rises++;
         gap = cycles - last_rise;
         last_rise = cycles;
         lvl_seen = click_level;
      end
      last_tone = click_tone;
      if (cycles == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_reg(input logic [15:0] g, e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: read %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_gain(input logic [6:0] g, e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: gain %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_count(input int g, e);
      comparisons++;
      if (g != e) begin
         n_mismatch++;
         $display("wrong value at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // model: flags come from the modelled gains, agc overrides two bits
   function automatic logic [15:0] exp_rd();
      logic [15:0] r;
      r = shadow;
      r[3] = lg == left_target;
      r[2] = rg == right_target;
      r[0] = agc_enable ? agc_saturated : ig == in_target;
      if (agc_enable) r[11] = agc_noise_below;
      return r;
   endfunction
   function automatic int step(int g, int t, int n);
      repeat (n) g += (t > g) - (g > t);
      return g;
   endfunction
   // flag bits never stored; the rate bit is frozen while agc runs
   task automatic put(input logic [15:0] d);
      host.wr(CTRL_OFFSET, d);
      shadow = {d[15:12], agc_enable ? shadow[11] : d[11], d[10:4], 2'b0,
                d[1], 1'b0};
   endtask
   task automatic look();
      host.rd(CTRL_OFFSET, got);
      check_reg(got, exp_rd());
   endtask
   // pulse held eight cycles so the pin synchroniser sees it cleanly
   task automatic tick(input logic a, b);
      @(negedge clk_sys);
      {wclk_pin, adc_word_strobe} = {a, b};
      repeat (8) @(negedge clk_sys);
      {wclk_pin, adc_word_strobe} = 2'b00;
      repeat (8) @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      look();
      // one burst per frequency code, settings retouched mid-burst
      for (int f = 0; f < 8; f++) begin
         v = $random(seed);
         per = BASE >> f;
         len = f < 3 ? {2'b00, v[1:0]} : v[3:0];
         w = {1'b1, v[6:4], shadow[11], 3'(f), len, 2'b00, shadow[1], 1'b0};
         rises = 0;
         last_rise = cycles;
         put(w);
         repeat (3) @(negedge clk_sys);
         put(w ^ 16'h7770);
         for (k = 0; k < 20000 && cycles - last_rise <= 2 * per + 4; k++)
            @(negedge clk_sys);
         check_count(rises, 2 * len + 2);
         check_count(gap, per);
         check_reg({13'b0, lvl_seen}, {13'b0, v[6:4]});
         shadow[15] = 1'b0;
         look();
      end
      put({1'b1, shadow[14:11], 3'b000, 4'hf, shadow[3:0]});
      repeat (100) @(negedge clk_sys);
      put({1'b0, shadow[14:0]});
      repeat (3) @(negedge clk_sys);
      rises = 0;
      check_reg({12'b0, click_tone, click_level}, 16'h0000);
      repeat (700) @(negedge clk_sys);
      check_count(rises, 0);
      // stepping at both rates; checked after each pair of ticks
      for (int r = 0; r < 2; r++) begin
         v = $random(seed);
         {left_target, right_target, in_target} =
            {7'h7f - v[2:0], 7'h78 + v[5:3], 7'h7c - v[8:6]};
         in_use_adc_strobe = r[0];
         put({shadow[15:12], r[0], shadow[10:2], r[0], 1'b0});
         look();
         for (k = 0; k < 8; k++) begin
            tick(1'b1, 1'b1);
            tick(1'b1, 1'b1);
            lg = step(lg, left_target, 2 - r);
            rg = step(rg, right_target, 2 - r);
            ig = step(ig, in_target, 2 - r);
            check_gain(left_gain, 7'(lg));
            check_gain(right_gain, 7'(rg));
            check_gain(in_gain, 7'(ig));
            look();
         end
      end
      left_target = left_target ^ 7'h01;
      in_target = in_target ^ 7'h01;
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b0);
      lg = step(lg, left_target, 1);
      check_gain(in_gain, 7'(ig));
      tick(1'b0, 1'b1);
      tick(1'b0, 1'b1);
      ig = step(ig, in_target, 1);
      check_gain(left_gain, 7'(lg));
      check_gain(in_gain, 7'(ig));
      // agc: noise and saturation shown, writes to flags dropped
      agc_enable = 1'b1;
      for (k = 0; k < 4; k++) begin
         v = $random(seed);
         {agc_noise_below, agc_saturated} = v[1:0];
         put(shadow ^ 16'h080d);
         look();
      end
      agc_enable = 1'b0;
      look();
      host.wr(8'h05, 16'hffff);
      host.rd(8'h05, got);
      check_reg(got, 16'h0000);
      look();
      print_verdict();
   end
endmodule // keyclick_and_gain_step_control_bench

// file: tb/kgc_ctrl_checker.sv
// checker: port-level assertions on the control register block
// assumes it is bound onto kgc_ctrl and sees only that module's ports
`timescale 1ns/1ps
module kgc_ctrl_checker #(
   parameter int unsigned CLICK_BASE_CYC = 32'd64 // click base count
) (
   input wire logic        clk_sys, // clock
   input wire logic        rst_n, // reset, low
   input wire logic [7:0]  reg_addr, // address
   input wire logic        reg_wr, // write strobe
   input wire logic        reg_rd, // read strobe
   input wire logic [15:0] reg_wdata, // write data
   input wire logic [15:0] reg_rdata, // read data
   input wire logic        wclk_pin, // word clock
   input wire logic        adc_word_strobe, // adc strobe
   input wire logic        in_use_adc_strobe, // input tick source
   input wire logic        agc_enable, // agc on
   input wire logic        agc_noise_below, // noise flag
   input wire logic        agc_saturated, // saturation flag
   input wire logic [6:0]  left_target, // left target
   input wire logic [6:0]  right_target, // right target
   input wire logic [6:0]  in_target, // input target
   input wire logic [6:0]  left_gain, // left applied
   input wire logic [6:0]  right_gain, // right applied
   input wire logic [6:0]  in_gain, // input applied
   input wire logic        click_tone, // tone
   input wire logic [2:0]  click_level // level
);
   import kgc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   logic [6:0] lt_q, rt_q, it_q; // last targets
   logic       le_q, re_q, ie_q; // last compares
   logic [2:0] lc_q, rc_q, ic_q; // settled run lengths
   logic [2:0] lc_d, rc_d, ic_d; // next run lengths
   wire        le = left_gain == left_target; // left settled
   wire        re = right_gain == right_target; // right settled
   wire        ie = in_gain == in_target; // input settled
   wire        rd4 = reg_rd && reg_addr == CTRL_OFFSET; // our read
   // saturating count; a flag is only judged once the compare sat still
   function automatic logic [2:0] bump(logic [2:0] c, logic clr);
      return clr ? 3'd0 : c + {2'b00, c != 3'd7};
   endfunction
   // agc hides the input flag, so its run restarts while agc is on
   always_comb begin
      lc_d = bump(lc_q, left_target != lt_q || le != le_q);
      rc_d = bump(rc_q, right_target != rt_q || re != re_q);
      ic_d = bump(ic_q, in_target != it_q || ie != ie_q || agc_enable);
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {lt_q, rt_q, it_q, le_q, re_q, ie_q} <= '0;
         {lc_q, rc_q, ic_q} <= '0;
      end else begin
         {lt_q, rt_q, it_q} <= {left_target, right_target, in_target};
         {le_q, re_q, ie_q} <= {le, re, ie};
         {lc_q, rc_q, ic_q} <= {lc_d, rc_d, ic_d};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_left_flag_read: assert property (rd4 && lc_q >= 3'd3
      |=> reg_rdata[3] == $past(le)) else $error("left flag wrong");
   a_right_flag_read: assert property (rd4 && rc_q >= 3'd3
      |=> reg_rdata[2] == $past(re)) else $error("right flag wrong");
   a_input_flag_read: assert property (rd4 && ic_q >= 3'd3
      |=> reg_rdata[0] == $past(ie)) else $error("input flag wrong");
   a_agc_flags_read: assert property (rd4 && agc_enable
      && $past(agc_enable) && $stable(agc_noise_below)
      && $stable(agc_saturated) |=> reg_rdata[11] == $past(agc_noise_below)
      && reg_rdata[0] == $past(agc_saturated)) else $error("agc flags");
   a_dac_single_step: assert property ($changed(left_gain)
      |-> left_gain - $past(left_gain) == 7'd1
      || $past(left_gain) - left_gain == 7'd1) else $error("gain jump");
   a_dac_step_tick: assert property ($changed(left_gain)
      |-> $past(wclk_pin, 2) && !$past(wclk_pin, 7))
      else $error("dac gain moved without word clock");
   a_input_step_source: assert property ($changed(in_gain)
      && $past(in_use_adc_strobe, 2) && $past(in_use_adc_strobe, 7)
      |-> $past(adc_word_strobe, 2) && !$past(adc_word_strobe, 7))
      else $error("input gain moved without adc strobe");
   a_click_abort: assert property (reg_wr && reg_addr == CTRL_OFFSET
      && !reg_wdata[15] |-> ##3 (!click_tone && click_level == 3'd0))
      else $error("click plays while disabled");
   a_level_latched: assert property ($past(click_level) != 3'd0
      && click_level != 3'd0 |-> $stable(click_level))
      else $error("level changed mid-burst");
   a_unmapped_read: assert property (reg_rd && reg_addr != CTRL_OFFSET
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule // kgc_ctrl_checker

bind kgc_ctrl kgc_ctrl_checker #(.CLICK_BASE_CYC(CLICK_BASE_CYC)) chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .wclk_pin(wclk_pin),
   .adc_word_strobe(adc_word_strobe),
   .in_use_adc_strobe(in_use_adc_strobe), .agc_enable(agc_enable),
   .agc_noise_below(agc_noise_below), .agc_saturated(agc_saturated),
   .left_target(left_target), .right_target(right_target),
   .in_target(in_target), .left_gain(left_gain),
   .right_gain(right_gain), .in_gain(in_gain),
   .click_tone(click_tone), .click_level(click_level));

// file: tb/kgc_host.sv
// host model: register writes and reads as driver software makes them
// assumes the block takes strobes on rising edges; we move on falling
`timescale 1ns/1ps
module kgc_host (
   input  wire logic [15:0] reg_rdata, // read data
   input  wire logic        clk_sys, // clock
   output logic      [7:0]  reg_addr, // address
   output logic             reg_wr, // write strobe
   output logic             reg_rd, // read strobe
   output logic      [15:0] reg_wdata // write data
);
   initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
   // one-cycle write; released data bus shows no stale value
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // read data is registered at the strobe edge and then held
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk_sys);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule // kgc_host
